// file: design/cdfh_pkg.sv
// Shared constants and types for the chopper decay and fault halt block
package cdfh_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 100;   // mclk period
  localparam int OSC_FREQ_KHZ    = 1600;  // Chop reference oscillator
  localparam int CHOP_FREQ_KHZ   = 100;   // Chopping rate
  localparam int OSC_PERIOD_NS   = 1000000 / OSC_FREQ_KHZ;
  localparam int OSC_DIV         = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CHOP_TICKS      = OSC_FREQ_KHZ / CHOP_FREQ_KHZ;
  localparam int ANA_BLANK_NS    = 550;   // Fixed noise blank
  localparam int ANA_BLANK_CYC   =
    (ANA_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIG_BLANK_OSC   = 4;     // Digital blank in osc periods
  localparam int DIG_BLANK_CYC   = DIG_BLANK_OSC * OSC_DIV;
  localparam int OC_DEAD_OSC     = 4;     // Over-current dead band
  localparam int OC_STOP_OSC     = 8;     // Latest over-current stop
  localparam int FAST_PCT_X10    = 375;   // Fast share of mixed decay
  localparam int FAST_TICKS      = (CHOP_TICKS * FAST_PCT_X10) / 1000;
  localparam int FAST_START      = CHOP_TICKS - FAST_TICKS;
  localparam int CLK_HIGH_NS     = 300;   // Step clock least high
  localparam int CLK_LOW_NS      = 250;   // Step clock least low
  localparam int CLK_HIGH_CYC    =
    (CLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_LOW_CYC     =
    (CLK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Sized forms of the counts
  // ****************************************
  localparam logic [2:0] OSC_DIV_LAST  = 3'(OSC_DIV - 1);
  localparam logic [3:0] CHOP_LAST     = 4'(CHOP_TICKS - 1);
  localparam logic [3:0] FAST_FROM     = 4'(FAST_START);
  localparam logic [4:0] ANA_BLANK     = 5'(ANA_BLANK_CYC);
  localparam logic [4:0] DIG_BLANK     = 5'(DIG_BLANK_CYC);
  localparam logic [3:0] OC_DEAD       = 4'(OC_DEAD_OSC);
  localparam logic [5:0] OC_DEAD_CYC   = 6'(OC_DEAD_OSC * OSC_DIV);
  localparam logic [5:0] OC_STOP_CYC   = 6'(OC_STOP_OSC * OSC_DIV);
  localparam logic [1:0] CLK_HIGH_MIN  = 2'(CLK_HIGH_CYC - 1);
  localparam logic [1:0] CLK_LOW_MIN   = 2'(CLK_LOW_CYC - 1);

  // ****************************************
  // Pin input positions in the synchroniser vector
  // ****************************************
  localparam int PIN_N     = 9;
  localparam int P_STEP    = 0;
  localparam int P_REV     = 1;
  localparam int P_DCMODE  = 2;
  localparam int P_STBY    = 3;
  localparam int P_SUPPLY  = 4;
  localparam int P_SETCUR  = 5;
  localparam int P_ZERO    = 6;
  localparam int P_THERM   = 7;
  localparam int P_OC      = 8;

  // Bridge phase
  typedef enum logic [2:0] {
    PH_OFF    = 3'h0,
    PH_CHARGE = 3'h1,
    PH_SLOW   = 3'h2,
    PH_FAST   = 3'h3,
    PH_DEAD   = 3'h4
  } cdfh_phase_t;

endpackage

// file: design/cdfh_core.sv
// Chopper decay sequencer with blanking and latched fault halt
`timescale 1ns/10ps
`default_nettype none

// Function
// - Over-temperature sets the halt and turns every bridge switch off.
// - A halt clears only on motor supply restart or standby entry.
// - Over-current halt turns all switches off until supply restart or standby entry.
// - Over-current ignored for a four-period dead band against switching spikes.
// - Analog blank about 550 ns; digital blank four oscillator periods.
// - Chop reference runs at 1600 kHz; chop period gives 100 kHz; the mclk divide by 6 gives about 1667 kHz and 104 kHz.
// - Each chop starts in charge, at set current goes slow, fast, charge.
// - Fast decay watches zero current; charge may start before or at zero.
// - Forward: charge high A low B; slow both low; fast high B low A.
// - Reverse: charge high B low A; slow both low; fast high A low B.
// - Phase choice is made internally, without controller direction.
// - Digital blank only in DC mode; stepping mode uses analog blank only.
// - DC start uses 37.5% mixed decay, charge held first four periods.
// - Outputs stop within eight periods of over-current, not before four.
module cdfh_core (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic step_clk,
  input  wire logic dir_reverse,
  input  wire logic dc_mode,
  input  wire logic standby,
  input  wire logic motor_supply,
  input  wire logic set_current_reached,
  input  wire logic zero_current,
  input  wire logic thermal_detect,
  input  wire logic overcurrent_detect,
  output logic      high_side_switch_a,
  output logic      high_side_switch_b,
  output logic      low_side_switch_a,
  output logic      low_side_switch_b,
  output logic      halted
);
  import cdfh_pkg::*;

  // ****************************************
  // State record
  // ****************************************
  typedef struct packed {
    logic [PIN_N-1:0] s1;
    logic [PIN_N-1:0] s2;
    logic [PIN_N-1:0] s3;
    logic [PIN_N-1:0] lvl;
    logic [2:0]       osc_div;
    logic             osc_tick;
    logic [3:0]       chop_cnt;
    logic [1:0]       run_cnt;
    logic             clk_filt;
    cdfh_phase_t      phase;
    cdfh_phase_t      target;
    logic [4:0]       blank_cnt;
    logic [3:0]       oc_age;
    logic [5:0]       oc_run;
    logic             halt;
    logic             hs_a;
    logic             hs_b;
    logic             ls_a;
    logic             ls_b;
  } cdfh_state_t;

  cdfh_state_t st_reg;
  cdfh_state_t st_next;
  logic [PIN_N-1:0] pins;
  logic             run;
  logic             chop_start;
  logic             blank_done;
  logic             restart;
  logic             fault;

  assign pins = {overcurrent_detect, thermal_detect, zero_current,
                 set_current_reached, motor_supply, standby, dc_mode,
                 dir_reverse, step_clk};

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_next = st_reg;
    // Pin synchroniser; a change counts once stages two and three agree
    st_next.s1  = pins;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    st_next.lvl = (st_reg.s2 & st_reg.s3) |
                  (st_reg.lvl & (st_reg.s2 | st_reg.s3));

    // Oscillator tick from the mclk divider
    st_next.osc_tick = 1'b0;
    if (st_reg.osc_div == OSC_DIV_LAST) begin
      st_next.osc_div  = 3'h0;
      st_next.osc_tick = 1'b1;
    end else begin
      st_next.osc_div = st_reg.osc_div + 3'h1;
    end
    chop_start = 1'b0;
    if (st_reg.osc_tick) begin
      chop_start = (st_reg.chop_cnt == CHOP_LAST);
      st_next.chop_cnt = chop_start ? 4'h0 : st_reg.chop_cnt + 4'h1;
    end

    // Step clock glitch filter
    if (st_reg.lvl[P_STEP] != st_reg.clk_filt) begin
      if (st_reg.run_cnt ==
          (st_reg.clk_filt ? CLK_LOW_MIN : CLK_HIGH_MIN)) begin
        st_next.clk_filt = st_reg.lvl[P_STEP];
        st_next.run_cnt  = 2'h0;
      end else begin
        st_next.run_cnt = st_reg.run_cnt + 2'h1;
      end
    end else begin
      st_next.run_cnt = 2'h0;
    end

    // Over-current must outlast four whole periods
    // One tick beyond the dead band: the first tick after onset may
    // come at once, so counting only four would halt too early
    if (!st_reg.lvl[P_OC]) begin
      st_next.oc_age = 4'h0;
    end else if (st_reg.osc_tick && st_reg.oc_age != OC_DEAD + 4'h1) begin
      st_next.oc_age = st_reg.oc_age + 4'h1;
    end
    fault = st_reg.lvl[P_THERM] ||
            (st_reg.lvl[P_OC] && st_reg.oc_age == OC_DEAD + 4'h1);

    // Over-current run length in mclk cycles for the stop bounds
    if (!st_reg.lvl[P_OC]) begin
      st_next.oc_run = 6'h00;
    end else if (st_reg.oc_run != OC_STOP_CYC) begin
      st_next.oc_run = st_reg.oc_run + 6'h01;
    end

    // Halt latch; a new fault wins over the clear
    restart = st_reg.lvl[P_STBY] || !st_reg.lvl[P_SUPPLY];
    if (fault) begin
      st_next.halt = 1'b1;
    end else if (restart) begin
      st_next.halt = 1'b0;
    end

    // Blank countdown
    if (st_reg.blank_cnt != 5'h0) begin
      st_next.blank_cnt = st_reg.blank_cnt - 5'h1;
    end
    blank_done = (st_reg.blank_cnt == 5'h0);
    // Digital blank on each step clock edge in DC mode
    if (st_reg.lvl[P_DCMODE] && st_next.clk_filt != st_reg.clk_filt) begin
      st_next.blank_cnt = DIG_BLANK;
    end

    // Decay sequencer chooses phases on its own
    run = st_reg.clk_filt && !st_next.halt && !restart;
    if (!run) begin
      st_next.phase = PH_OFF;
    end else begin
      unique case (st_reg.phase)
        PH_OFF: begin
          st_next.phase  = PH_DEAD;
          st_next.target = PH_CHARGE;
        end
        PH_CHARGE: begin
          // Current limit seen only after the blank
          if (blank_done && st_reg.lvl[P_SETCUR]) begin
            st_next.phase  = PH_DEAD;
            st_next.target = (st_reg.chop_cnt >= FAST_FROM) ? PH_FAST
                                                           : PH_SLOW;
          end
        end
        PH_SLOW: begin
          if (chop_start) begin
            st_next.phase  = PH_DEAD;
            st_next.target = PH_CHARGE;
          end else if (st_reg.osc_tick &&
                       st_reg.chop_cnt + 4'h1 == FAST_FROM) begin
            st_next.phase  = PH_DEAD;
            st_next.target = PH_FAST;
          end
        end
        PH_FAST: begin
          // Charge at period end or at zero current
          if (chop_start || st_reg.lvl[P_ZERO]) begin
            st_next.phase  = PH_DEAD;
            st_next.target = PH_CHARGE;
          end
        end
        PH_DEAD: begin
          // One cycle all off between phases
          st_next.phase = st_reg.target;
          if (st_reg.target == PH_CHARGE) begin
            // Analog blank in stepping mode; digital blank in DC mode
            st_next.blank_cnt = st_reg.lvl[P_DCMODE] ? DIG_BLANK
                                                     : ANA_BLANK;
          end
        end
        default: begin
          st_next.phase = PH_OFF;
        end
      endcase
    end

    // Switch map from phase and direction
    st_next.hs_a = 1'b0;
    st_next.hs_b = 1'b0;
    st_next.ls_a = 1'b0;
    st_next.ls_b = 1'b0;
    if (st_next.phase == PH_SLOW) begin
      st_next.ls_a = 1'b1;
      st_next.ls_b = 1'b1;
    // Forward charge and reverse fast share high A with low B
    end else if (((st_next.phase == PH_CHARGE) ^ st_next.lvl[P_REV]) &&
                 (st_next.phase == PH_CHARGE ||
                  st_next.phase == PH_FAST)) begin
      st_next.hs_a = 1'b1;
      st_next.ls_b = 1'b1;
    end else if (st_next.phase == PH_CHARGE ||
                 st_next.phase == PH_FAST) begin
      st_next.hs_b = 1'b1;
      st_next.ls_a = 1'b1;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign high_side_switch_a = st_reg.hs_a;
  assign high_side_switch_b = st_reg.hs_b;
  assign low_side_switch_a  = st_reg.ls_a;
  assign low_side_switch_b  = st_reg.ls_b;
  assign halted             = st_reg.halt;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_leg_a_safe: assert property (!(st_reg.hs_a && st_reg.ls_a))
    else $error("leg a shoot-through");
  a_leg_b_safe: assert property (!(st_reg.hs_b && st_reg.ls_b))
    else $error("leg b shoot-through");
  a_halt_all_off: assert property (st_reg.halt |->
    !(st_reg.hs_a || st_reg.hs_b || st_reg.ls_a || st_reg.ls_b))
    else $error("switch on while halted");
  a_thermal_halt: assert property (st_reg.lvl[P_THERM] |=>
    st_reg.halt && !(st_reg.hs_a || st_reg.hs_b ||
                     st_reg.ls_a || st_reg.ls_b))
    else $error("thermal fault did not halt");
  a_restart_clear: assert property ((st_reg.lvl[P_STBY] ||
    !st_reg.lvl[P_SUPPLY]) && !st_reg.lvl[P_THERM] && !st_reg.lvl[P_OC]
    |=> !st_reg.halt)
    else $error("restart did not clear halt");
  a_halt_sticky: assert property (st_reg.halt &&
    st_reg.lvl[P_STBY] == 1'b0 && st_reg.lvl[P_SUPPLY] |=> st_reg.halt)
    else $error("halt released without restart");
  a_oc_dead_band: assert property ($rose(st_reg.lvl[P_OC]) &&
    !st_reg.halt && !st_reg.lvl[P_THERM] && !st_next.halt
    ##1 !st_reg.lvl[P_THERM] |-> !st_reg.halt[*8])
    else $error("over-current halt inside dead band");
  // Halt latched by eight periods of lasting over-current
  a_oc_stop_bound: assert property (st_reg.oc_run == OC_STOP_CYC
    |-> st_reg.halt)
    else $error("over-current halt too late");
  // Over-current halt never before four whole periods
  a_oc_not_early: assert property ($rose(st_reg.halt) &&
    !$past(st_reg.lvl[P_THERM]) |-> $past(st_reg.oc_run) >= OC_DEAD_CYC)
    else $error("over-current halt before four periods");
  a_charge_fwd: assert property (st_reg.phase == PH_CHARGE &&
    !st_reg.lvl[P_REV] |-> st_reg.hs_a && st_reg.ls_b)
    else $error("forward charge map wrong");
  a_charge_rev: assert property (st_reg.phase == PH_CHARGE &&
    st_reg.lvl[P_REV] |-> st_reg.hs_b && st_reg.ls_a)
    else $error("reverse charge map wrong");
  a_slow_map: assert property (st_reg.phase == PH_SLOW |->
    st_reg.ls_a && st_reg.ls_b && !st_reg.hs_a && !st_reg.hs_b)
    else $error("slow decay map wrong");
  a_fast_map: assert property (st_reg.phase == PH_FAST |->
    (st_reg.lvl[P_REV] ? st_reg.hs_a && st_reg.ls_b && !st_reg.hs_b
                       : st_reg.hs_b && st_reg.ls_a && !st_reg.hs_a))
    else $error("fast decay map wrong");
  a_blank_hold: assert property (st_reg.phase == PH_CHARGE &&
    st_reg.blank_cnt != 5'h0 && !st_next.halt && run
    |=> st_reg.phase == PH_CHARGE)
    else $error("charge left during blank");

  c_slow_entry: cover property (st_reg.phase == PH_SLOW);
  c_fast_entry: cover property (st_reg.phase == PH_FAST);
  c_zero_charge: cover property (st_reg.phase == PH_FAST &&
    st_reg.lvl[P_ZERO] ##2 st_reg.phase == PH_CHARGE);
  c_halt_clear: cover property (st_reg.halt ##1 !st_reg.halt);
  c_oc_halt: cover property (st_reg.lvl[P_OC] && $rose(st_reg.halt));

endmodule

`default_nettype wire

// file: verif/cdfh_winding_model.sv
// Behavioural motor winding that answers the bridge switch states
`timescale 1ns/10ps
`default_nettype none
module cdfh_winding_model #(
  parameter int SET_LEVEL = 20
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic dir_reverse,
  input  wire logic high_side_switch_a,
  input  wire logic high_side_switch_b,
  input  wire logic low_side_switch_a,
  input  wire logic low_side_switch_b,
  output logic      set_current_reached,
  output logic      zero_current
);
  logic [3:0] sw;
  logic [3:0] chg;
  int         cur;
  // Switch vector and the pair that charges for this direction
  assign sw  = {high_side_switch_a, high_side_switch_b,
                low_side_switch_a, low_side_switch_b};
  assign chg = dir_reverse ? 4'h6 : 4'h9;
  // Current rises in charge, holds in slow decay, falls otherwise
  always @(posedge mclk) begin
    if (rst)
      cur <= 0;
    else if (sw == chg)
      cur <= cur + 1;
    else if (sw != 4'h3)
      cur <= (cur > 2) ? cur - 2 : 0;
  end
  // Sense outputs seen by the chopper
  assign set_current_reached = (cur >= SET_LEVEL);
  assign zero_current        = (cur == 0);
endmodule
`default_nettype wire

// file: verif/chopper_decay_and_fault_halt_tb.sv
// Self-checking bench for the chopper decay and fault halt block
`timescale 1ns/10ps
`default_nettype none
module chopper_decay_and_fault_halt_tb;
  typedef struct {logic rev; logic dc; logic [3:0] chg; logic [3:0] fst;}
    cdfh_row_t;
  cdfh_row_t rows [4] = '{'{1'b0, 1'b0, 4'h9, 4'h6},
                          '{1'b1, 1'b0, 4'h6, 4'h9},
                          '{1'b0, 1'b1, 4'h9, 4'h6},
                          '{1'b1, 1'b1, 4'h6, 4'h9}};
  logic mclk = 1'b0, rst = 1'b1, step_clk = 1'b0, dir_reverse = 1'b0;
  logic dc_mode = 1'b0, standby = 1'b0, motor_supply = 1'b1;
  logic thermal_detect = 1'b0, overcurrent_detect = 1'b0;
  logic set_current_reached, zero_current, halted;
  logic hs_a, hs_b, ls_a, ls_b;
  logic [3:0] p, seen;
  int err_count = 0, checked = 0;
  // ****************************************
  // Clock, design and winding
  // ****************************************
  always #50 mclk = ~mclk;
  assign p = {hs_a, hs_b, ls_a, ls_b};
  cdfh_core uut (.mclk(mclk), .rst(rst), .step_clk(step_clk),
    .dir_reverse(dir_reverse), .dc_mode(dc_mode), .standby(standby),
    .motor_supply(motor_supply), .set_current_reached(set_current_reached),
    .zero_current(zero_current), .thermal_detect(thermal_detect),
    .overcurrent_detect(overcurrent_detect), .high_side_switch_a(hs_a),
    .high_side_switch_b(hs_b), .low_side_switch_a(ls_a),
    .low_side_switch_b(ls_b), .halted(halted));
  cdfh_winding_model wind (.mclk(mclk), .rst(rst), .dir_reverse(dir_reverse),
    .high_side_switch_a(hs_a), .high_side_switch_b(hs_b),
    .low_side_switch_a(ls_a), .low_side_switch_b(ls_b),
    .set_current_reached(set_current_reached), .zero_current(zero_current));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic end_sim;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Run one mode row and watch every phase pattern
  task automatic run_row(input cdfh_row_t r);
    logic [3:0] prev, first;
    logic       bad, sc, ss, sf;
    prev = 4'h0; first = 4'h0; bad = 1'b0; sc = 1'b0; ss = 1'b0; sf = 1'b0;
    @(posedge mclk);
    step_clk <= 1'b0;
    wait_cyc(20);
    @(posedge mclk);
    dir_reverse <= r.rev;
    dc_mode     <= r.dc;
    wait_cyc(8);
    @(posedge mclk);
    step_clk <= 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(negedge mclk);
      if (first == 4'h0) first = p;
      if (p == r.chg) sc = 1'b1;
      else if (p == 4'h3) ss = 1'b1;
      else if (p == r.fst) sf = 1'b1;
      else if (p != 4'h0) bad = 1'b1;
      if (p != 4'h0 && prev != 4'h0 && p != prev) bad = 1'b1;
      prev = p;
    end
    chk(first, r.chg);
    chk({bad, sc, ss, sf}, 4'h7);
  endtask
  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    wait_cyc(6000);
    err_count++;
    end_sim;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    wait_cyc(3);
    chk(p | {3'h0, halted}, 4'h0);
    @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[i]) run_row(rows[i]);
    // Second reset in mid-drive
    @(posedge mclk);
    rst <= 1'b1;
    wait_cyc(2);
    chk(p, 4'h0);
    @(posedge mclk);
    rst <= 1'b0;
    // Short step pulse is filtered out
    step_clk <= 1'b0;
    dc_mode  <= 1'b0;
    wait_cyc(20);
    @(posedge mclk);
    step_clk <= 1'b1;
    @(posedge mclk);
    @(posedge mclk);
    step_clk <= 1'b0;
    seen = 4'h0;
    repeat (20) begin
      @(negedge mclk);
      seen = seen | p;
    end
    chk(seen, 4'h0);
    @(posedge mclk);
    step_clk <= 1'b1;
    wait_cyc(40);
    // Thermal halt, held through step activity, cleared by standby
    @(posedge mclk);
    thermal_detect <= 1'b1;
    wait_cyc(8);
    chk({halted, p[3:1]} | {3'h0, p[0]}, 4'h8);
    @(posedge mclk);
    thermal_detect <= 1'b0;
    wait_cyc(60);
    chk({halted, p[3:1]} | {3'h0, p[0]}, 4'h8);
    @(posedge mclk);
    standby <= 1'b1;
    wait_cyc(10);
    @(posedge mclk);
    standby <= 1'b0;
    wait_cyc(10);
    chk({3'h0, halted}, 4'h0);
    wait_cyc(40);
    // Over-current shorter than the dead band
    @(posedge mclk);
    overcurrent_detect <= 1'b1;
    wait_cyc(10);
    @(posedge mclk);
    overcurrent_detect <= 1'b0;
    wait_cyc(40);
    chk({3'h0, halted}, 4'h0);
    // Lasting over-current halts inside the allowed span
    @(posedge mclk);
    overcurrent_detect <= 1'b1;
    wait_cyc(28);
    chk({3'h0, halted}, 4'h0);
    wait_cyc(8);
    chk({halted, p[3:1]} | {3'h0, p[0]}, 4'h8);
    wait_cyc(20);
    @(posedge mclk);
    overcurrent_detect <= 1'b0;
    wait_cyc(40);
    chk({3'h0, halted}, 4'h1);
    // Motor supply restart clears the halt; drive withdrawn
    @(posedge mclk);
    step_clk     <= 1'b0;
    motor_supply <= 1'b0;
    wait_cyc(10);
    @(posedge mclk);
    motor_supply <= 1'b1;
    wait_cyc(10);
    chk({3'h0, halted}, 4'h0);
    // Drive resumes after the restart, reverse charge first
    @(posedge mclk);
    step_clk <= 1'b1;
    wait_cyc(20);
    chk(p, 4'h6);
    end_sim;
  end
endmodule
`default_nettype wire
